// [core/pll_ctrl_regs.svh]
`ifndef PLL_CTRL_REGS_SVH
`define PLL_CTRL_REGS_SVH

`define WORD_W 32
`define ADDR_W 5
`define STORE_W 27
`define COUNT_W 6
`define FRAC_W 25
`define ADDR_MSB 4
`define FIELD_LSB 5
`define REG_ADDR 5'h0C
`define WORD_BITS 6'h20
`define RESET_FIELDS 27'h2500F80
`define B_LOOP_PD 5
`define B_PUMP_PD 6
`define B_OSC_PD 7
`define B_MUX_PD 8
`define B_FBDIV_PD 9
`define B_PRESC_PD 10
`define B_RSV 11
`define B_OBUF_PD 12
`define B_OCDIV_PD 13
`define B_MCDIV_PD 14
`define B_BBCM_PD 15
`define B_BBOFF_PD 16
`define B_EXTOSC_EN 17
`define B_OFFCUR_EN 18
`define B_ALOCK_LO 19
`define B_ALOCK_HI 20
`define B_FORCE_LO 21
`define B_FORCE_HI 22
`define B_SETTLE 23
`define B_DLOCK 24
`define B_DITH_EN 25
`define B_ORDER_LO 26
`define B_ORDER_HI 27
`define B_DITHER_TYPE_SELECT 28
`define B_DELAY_LO 29
`define B_DELAY_HI 30
`define B_FRAC_EN 31

`endif

// [core/pll_ctrl_pkg.sv]
package pll_ctrl_pkg;

    typedef enum logic [1:0] {
        PUMP_NORMAL = 2'h0,
        PUMP_DOWN = 2'h1,
        PUMP_UP = 2'h2,
        PUMP_HIGH_Z = 2'h3
    } pump_force_t;

    typedef struct packed {
        logic loop_all_powerdown;
        logic pump_powerdown;
        logic oscillator_powerdown;
        logic oscillator_select_mux_powerdown;
        logic feedback_divider_powerdown;
        logic prescaler_powerdown;
        logic output_buffer_powerdown;
        logic output_chain_divider_powerdown;
        logic modulator_chain_divider_powerdown;
        logic baseband_common_mode_powerdown;
        logic baseband_offset_powerdown;
        logic external_oscillator_input_enable;
        logic pump_offset_current_enable;
        logic [1:0] analog_lock_precision;
        pump_force_t pump_force_state;
        logic bias_settle_bypass;
        logic digital_lock_precision;
        logic dither_enable;
        logic [1:0] modulator_order;
        logic dither_type_select;
        logic [1:0] modulator_clock_delay;
        logic fractional_mode_enable;
    } ctrl_fields_t;

endpackage

// [core/bit_sync.sv]
`timescale 1ns/1ps
module bit_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic stage1;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage1 <= 1'b0;
            q_o <= 1'b0;
        end else begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule

// [core/serial_shift_rx.sv]
`timescale 1ns/1ps
`include "pll_ctrl_regs.svh"
module serial_shift_rx (
    // link clock and reset
    input wire logic link_clock_i,
    input wire logic link_reset_i,
    // serial data
    input wire logic link_data_i,
    // shifted word and running bit count
    output logic [`WORD_W-1:0] word_o,
    output logic [`COUNT_W-1:0] count_o
);
    wire [`WORD_W-1:0] next_word = {link_data_i, word_o[`WORD_W-1:1]};
    wire [`COUNT_W-1:0] next_count = count_o + `COUNT_W'(1);

    // lsb first: after a full frame bit 0 sits at word_o[0]
    always_ff @(posedge link_clock_i) begin
        if (link_reset_i) begin
            word_o <= '0;
            count_o <= '0;
        end else begin
            word_o <= next_word;
            count_o <= next_count;
        end
    end
endmodule

// [core/pll_power_mod_ctrl.sv]
// Function
// - address bits 4..0 equal 01100 select word
// - bit5 loop powerdown, bit7 oscillator off
// - bit6 turns charge pump off
// - bit8 powers down oscillator select mux
// - bit9 feedback divider, bit10 prescaler powerdown
// - bits12..16 chain powerdowns, reset to one
// - bit17 enables external oscillator input
// - bit18 pump offset current, fractional only; passed out as written, not gated by bit31
// - bits20..19 analog lock precision, reset 00
// - bits22..21 force pump state, reset normal
// - bit23 bypasses bias settling capacitors
// - bit24 lengthens digital lock sampling
// - bit25 dither enable, resets to one
// - bits27..26 modulator order, reset 10
// - bit28 dither type: constant or random
// - bits30..29 modulator clock delay, reset 10
// - bit31 enables fractional division mode
// - fractional mode uses separate 25-bit value
`timescale 1ns/1ps
`include "pll_ctrl_regs.svh"
module pll_power_mod_ctrl
    import pll_ctrl_pkg::*;
(
    // system clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // three-wire serial link
    input wire logic link_clock_i,
    input wire logic link_data_i,
    input wire logic link_latch_i,
    // fractional value from its own register
    input wire logic [`FRAC_W-1:0] fractional_divider_value_i,
    // control outputs
    output ctrl_fields_t ctrl_o,
    output logic [`FRAC_W-1:0] fractional_divider_value_o,
    // write status
    output logic word_taken_o,
    output logic word_ignored_o
);

    // ****************************************
    // field decode
    // ****************************************
    function automatic ctrl_fields_t field_decode(input logic [`WORD_W-1:0] w);
        ctrl_fields_t f;
        f = '0;
        f.loop_all_powerdown = w[`B_LOOP_PD];
        f.oscillator_powerdown = w[`B_OSC_PD];
        f.pump_powerdown = w[`B_PUMP_PD];
        f.oscillator_select_mux_powerdown = w[`B_MUX_PD];
        f.feedback_divider_powerdown = w[`B_FBDIV_PD];
        f.prescaler_powerdown = w[`B_PRESC_PD];
        f.output_buffer_powerdown = w[`B_OBUF_PD];
        f.output_chain_divider_powerdown = w[`B_OCDIV_PD];
        f.modulator_chain_divider_powerdown = w[`B_MCDIV_PD];
        f.baseband_common_mode_powerdown = w[`B_BBCM_PD];
        f.baseband_offset_powerdown = w[`B_BBOFF_PD];
        f.external_oscillator_input_enable = w[`B_EXTOSC_EN];
        f.pump_offset_current_enable = w[`B_OFFCUR_EN];
        f.analog_lock_precision = w[`B_ALOCK_HI:`B_ALOCK_LO];
        f.pump_force_state = pump_force_t'(w[`B_FORCE_HI:`B_FORCE_LO]);
        f.bias_settle_bypass = w[`B_SETTLE];
        f.digital_lock_precision = w[`B_DLOCK];
        f.dither_enable = w[`B_DITH_EN];
        f.modulator_order = w[`B_ORDER_HI:`B_ORDER_LO];
        f.dither_type_select = w[`B_DITHER_TYPE_SELECT];
        f.modulator_clock_delay = w[`B_DELAY_HI:`B_DELAY_LO];
        f.fractional_mode_enable = w[`B_FRAC_EN];
        return f;
    endfunction

    // ****************************************
    // link side
    // ****************************************
    logic link_reset;
    logic [`WORD_W-1:0] rx_word;
    logic [`COUNT_W-1:0] rx_count;

    bit_sync u_link_reset (
        .clk_i(link_clock_i),
        .reset_i(1'b0),
        .d_i(reset_i),
        .q_o(link_reset)
    );

    serial_shift_rx u_rx (
        .link_clock_i(link_clock_i),
        .link_reset_i(link_reset),
        .link_data_i(link_data_i),
        .word_o(rx_word),
        .count_o(rx_count)
    );

    // ****************************************
    // latch strobe crossing
    // ****************************************
    logic latch_sync;
    logic latch_prev;

    bit_sync u_latch_sync (
        .clk_i(clock_i),
        .reset_i(reset_i),
        .d_i(link_latch_i),
        .q_o(latch_sync)
    );

    // rx word and count are still while latch is high and link clock idle
    wire latch_rise = latch_sync & ~latch_prev;

    // ****************************************
    // write qualification
    // ****************************************
    logic [`COUNT_W-1:0] last_count;
    logic [`STORE_W-1:0] fields;

    wire [`COUNT_W-1:0] count_delta = rx_count - last_count;
    wire full_word = (count_delta == `WORD_BITS);
    wire addr_hit = (rx_word[`ADDR_MSB:0] == `REG_ADDR);
    wire take = latch_rise & full_word & addr_hit;
    wire ignore = latch_rise & ~take;
    wire [`STORE_W-1:0] next_fields =
        take ? rx_word[`WORD_W-1:`FIELD_LSB] : fields;
    wire [`COUNT_W-1:0] next_last_count = latch_rise ? rx_count : last_count;
    wire [`WORD_W-1:0] next_word = {next_fields, `REG_ADDR};
    wire ctrl_fields_t next_ctrl = field_decode(next_word);
    wire [`FRAC_W-1:0] next_frac =
        next_ctrl.fractional_mode_enable ? fractional_divider_value_i
                                         : `FRAC_W'(0);

    // ****************************************
    // stored word and outputs
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            latch_prev <= 1'b0;
            last_count <= '0;
        end else begin
            latch_prev <= latch_sync;
            last_count <= next_last_count;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fields <= `RESET_FIELDS;
        end else begin
            fields <= next_fields;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_o <= field_decode({`RESET_FIELDS, `REG_ADDR});
            fractional_divider_value_o <= '0;
            word_taken_o <= 1'b0;
            word_ignored_o <= 1'b0;
        end else begin
            ctrl_o <= next_ctrl;
            fractional_divider_value_o <= next_frac;
            word_taken_o <= take;
            word_ignored_o <= ignore;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    property p_reset_values;
        $fell(reset_i) |-> ctrl_o == field_decode({`RESET_FIELDS, `REG_ADDR})
            && fractional_divider_value_o == '0;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    property p_addr_select;
        word_taken_o |-> $past(rx_word[`ADDR_MSB:0]) == `REG_ADDR;
    endproperty
    a_addr_select: assert property (p_addr_select)
        else $error("write taken with wrong address");

    property p_wrong_addr_hold;
        latch_rise && !addr_hit |=> word_ignored_o && $stable(ctrl_o);
    endproperty
    a_wrong_addr_hold: assert property (p_wrong_addr_hold)
        else $error("foreign address changed fields");

    property p_change_only_on_take;
        $changed(fields) |-> word_taken_o;
    endproperty
    a_change_only_on_take: assert property (p_change_only_on_take)
        else $error("fields changed without write");

    property p_whole_update;
        take |=> fields == $past(rx_word[`WORD_W-1:`FIELD_LSB]) ##1 $stable(fields)
            || word_taken_o;
    endproperty
    a_whole_update: assert property (p_whole_update)
        else $error("fields not loaded whole");

    property p_loop_osc;
        word_taken_o |-> ctrl_o.loop_all_powerdown == $past(rx_word[`B_LOOP_PD])
            && ctrl_o.oscillator_powerdown == $past(rx_word[`B_OSC_PD]);
    endproperty
    a_loop_osc: assert property (p_loop_osc)
        else $error("loop or oscillator powerdown wrong");

    property p_pump_pd;
        word_taken_o |-> ctrl_o.pump_powerdown == $past(rx_word[`B_PUMP_PD]);
    endproperty
    a_pump_pd: assert property (p_pump_pd)
        else $error("pump powerdown wrong");

    property p_mux_pd;
        word_taken_o |->
            ctrl_o.oscillator_select_mux_powerdown == $past(rx_word[`B_MUX_PD]);
    endproperty
    a_mux_pd: assert property (p_mux_pd)
        else $error("mux powerdown wrong");

    property p_div_presc;
        word_taken_o |-> ctrl_o.feedback_divider_powerdown == $past(rx_word[`B_FBDIV_PD])
            && ctrl_o.prescaler_powerdown == $past(rx_word[`B_PRESC_PD]);
    endproperty
    a_div_presc: assert property (p_div_presc)
        else $error("divider or prescaler powerdown wrong");

    property p_chain_pd;
        word_taken_o |-> ctrl_o.baseband_offset_powerdown == $past(rx_word[`B_BBOFF_PD])
            && ctrl_o.output_buffer_powerdown == $past(rx_word[`B_OBUF_PD])
            && ctrl_o.output_chain_divider_powerdown == $past(rx_word[`B_OCDIV_PD])
            && ctrl_o.modulator_chain_divider_powerdown == $past(rx_word[`B_MCDIV_PD])
            && ctrl_o.baseband_common_mode_powerdown == $past(rx_word[`B_BBCM_PD]);
    endproperty
    a_chain_pd: assert property (p_chain_pd)
        else $error("chain powerdown wrong");

    property p_ext_osc;
        word_taken_o |->
            ctrl_o.external_oscillator_input_enable == $past(rx_word[`B_EXTOSC_EN]);
    endproperty
    a_ext_osc: assert property (p_ext_osc)
        else $error("external input enable wrong");

    property p_offset_cur;
        word_taken_o |->
            ctrl_o.pump_offset_current_enable == $past(rx_word[`B_OFFCUR_EN]);
    endproperty
    a_offset_cur: assert property (p_offset_cur)
        else $error("offset current enable wrong");

    property p_analog_prec;
        word_taken_o |->
            ctrl_o.analog_lock_precision == $past(rx_word[`B_ALOCK_HI:`B_ALOCK_LO]);
    endproperty
    a_analog_prec: assert property (p_analog_prec)
        else $error("analog lock precision wrong");

    property p_pump_force;
        word_taken_o |->
            ctrl_o.pump_force_state == $past(rx_word[`B_FORCE_HI:`B_FORCE_LO]);
    endproperty
    a_pump_force: assert property (p_pump_force)
        else $error("pump force state wrong");

    property p_settle_dlock;
        word_taken_o |-> ctrl_o.bias_settle_bypass == $past(rx_word[`B_SETTLE])
            && ctrl_o.digital_lock_precision == $past(rx_word[`B_DLOCK]);
    endproperty
    a_settle_dlock: assert property (p_settle_dlock)
        else $error("settle bypass or digital precision wrong");

    property p_dither;
        word_taken_o |-> ctrl_o.dither_enable == $past(rx_word[`B_DITH_EN])
            && ctrl_o.dither_type_select == $past(rx_word[`B_DITHER_TYPE_SELECT]);
    endproperty
    a_dither: assert property (p_dither)
        else $error("dither control wrong");

    property p_order_delay;
        word_taken_o |->
            ctrl_o.modulator_order == $past(rx_word[`B_ORDER_HI:`B_ORDER_LO])
            && ctrl_o.modulator_clock_delay == $past(rx_word[`B_DELAY_HI:`B_DELAY_LO]);
    endproperty
    a_order_delay: assert property (p_order_delay)
        else $error("modulator order or delay wrong");

    property p_frac_en;
        word_taken_o |-> ctrl_o.fractional_mode_enable == $past(rx_word[`B_FRAC_EN]);
    endproperty
    a_frac_en: assert property (p_frac_en)
        else $error("fractional enable wrong");

    property p_frac_value;
        ##1 (ctrl_o.fractional_mode_enable
            ? fractional_divider_value_o == $past(fractional_divider_value_i)
            : fractional_divider_value_o == '0);
    endproperty
    a_frac_value: assert property (p_frac_value)
        else $error("fractional value path wrong");

    c_take: cover property (latch_rise && take);
    c_wrong_addr: cover property (latch_rise && full_word && !addr_hit);
    c_short_frame: cover property (latch_rise && !full_word);
    c_frac_on: cover property (word_taken_o && ctrl_o.fractional_mode_enable);

endmodule

// [verif/host_link_model.sv]
`timescale 1ns/1ps
// ****************************************
// host side of the three-wire link
// ****************************************
module host_link_model (
    // serial link toward the device
    output logic link_clock_o,
    output logic link_data_o,
    output logic link_latch_o
);
    initial begin
        link_clock_o = 1'b0;
        link_data_o = 1'b1;
        link_latch_o = 1'b0;
    end

    // free pulses, only used around reset
    task automatic pulse_clock(input int n);
        for (int i = 0; i < n; i++) begin
            #15 link_clock_o = 1'b1;
            #15 link_clock_o = 1'b0;
        end
    endtask

    // lsb first, data set half a period ahead of each rise
    task automatic shift(input logic [95:0] data, input int nbits);
        #3.7;
        for (int i = 0; i < nbits; i++) begin
            link_data_o = (i == nbits - 21) ? 1'b0 : data[i];
            #15 link_clock_o = 1'b1;
            #15 link_clock_o = 1'b0;
        end
        // released line shows the inverse of the last bit
        link_data_o = ~link_data_o;
    endtask

    // clock stays idle while the strobe is high
    task automatic latch_on();
        #15 link_latch_o = 1'b1;
    endtask

    task automatic latch_off();
        link_latch_o = 1'b0;
        #20;
    endtask
endmodule

// [verif/pll_power_and_modulator_control_word_bench.sv]
`timescale 1ns/1ps
// ****************************************
// bench for the power and modulator control word
// ****************************************
module pll_power_and_modulator_control_word_bench
    import pll_ctrl_pkg::*;
;
    logic clock_i;
    logic reset_i;
    logic [24:0] frac_i;
    wire link_clock;
    wire link_data;
    wire link_latch;
    ctrl_fields_t ctrl_o;
    logic [24:0] frac_o;
    logic word_taken_o;
    logic word_ignored_o;
    int n_mismatch;
    int cmp_count;
    logic [31:0] cur_word;
    logic [4:0] bad_addr [5] = '{5'h0B, 5'h0D, 5'h1C, 5'h04, 5'h00};

    initial begin
        clock_i = 1'b0;
        reset_i = 1'b1;
        frac_i = 25'h0;
        n_mismatch = 0;
        cmp_count = 0;
        cur_word = 32'h4A01F00C;
    end

    always #2.5 clock_i = ~clock_i;

    host_link_model host (
        .link_clock_o(link_clock),
        .link_data_o(link_data),
        .link_latch_o(link_latch)
    );

    pll_power_mod_ctrl uut (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .link_clock_i(link_clock),
        .link_data_i(link_data),
        .link_latch_i(link_latch),
        .fractional_divider_value_i(frac_i),
        .ctrl_o(ctrl_o),
        .fractional_divider_value_o(frac_o),
        .word_taken_o(word_taken_o),
        .word_ignored_o(word_ignored_o)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic ctrl_fields_t exp_fields(input logic [31:0] w);
        return ctrl_fields_t'({w[5], w[6], w[7], w[8], w[9], w[10], w[12], w[13], w[14],
            w[15], w[16], w[17], w[18], w[20:19], w[22:21], w[23], w[24], w[25],
            w[27:26], w[28], w[30:29], w[31]});
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic write_word(input logic [95:0] data, input int nbits, input logic take);
        logic [31:0] word;
        logic seen;
        int n;
        word = (nbits >= 32) ? data[nbits-32 +: 32] : cur_word;
        host.shift(data, nbits);
        check("ctrl before latch", 32'(ctrl_o), 32'(exp_fields(cur_word)));
        host.latch_on();
        seen = 1'b0;
        n = 0;
        while (!seen) begin
            @(posedge clock_i);
            #1;
            n++;
            if (word_taken_o === 1'b1 || word_ignored_o === 1'b1) begin
                seen = 1'b1;
            end else if (n > 20) begin
                n_mismatch++;
                $display("MISMATCH answer pulse expected 1 seen 0");
                finish_test();
            end
        end
        if (take) begin
            cur_word = word;
        end
        check("taken", 32'(word_taken_o), 32'(take));
        check("ignored", 32'(word_ignored_o), 32'(!take));
        check("ctrl", 32'(ctrl_o), 32'(exp_fields(cur_word)));
        @(posedge clock_i);
        frac_i <= word[29:5];
        #1;
        check("pulses", 32'({word_taken_o, word_ignored_o}), 32'h0);
        host.latch_off();
        @(posedge clock_i);
        @(posedge clock_i);
        #1;
        check("fraction", 32'(frac_o), cur_word[31] ? 32'(word[29:5]) : 32'h0);
    endtask

    task automatic do_reset();
        @(posedge clock_i);
        reset_i <= 1'b1;
        host.pulse_clock(4);
        @(posedge clock_i);
        reset_i <= 1'b0;
        host.pulse_clock(3);
        repeat (3) @(posedge clock_i);
        #1;
        cur_word = 32'h4A01F00C;
        check("ctrl reset", 32'(ctrl_o), 32'(exp_fields(cur_word)));
        check("fraction reset", 32'(frac_o), 32'h0);
        // clears any bits counted while the link reset let go
        write_word(96'h0, 0, 1'b0);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] k;
        do_reset();
        for (int b = 5; b < 32; b++) begin
            if (b != 11) begin
                // offset current only together with fractional mode
                k = (32'h1 << b) | ((b == 18) ? 32'h8000000C : 32'h0000000C);
                write_word(96'(k), 32, 1'b1);
            end
        end
        for (int c = 0; c < 4; c++) begin
            k = 32'(c);
            k = 32'h8004000C | (k << 19) | (k << 21) | (k << 26) | (k << 29);
            write_word(96'(k), 32, 1'b1);
        end
        for (int a = 0; a < 5; a++) begin
            write_word(96'(32'hFFFFF7E0 | 32'(bad_addr[a])), 32, 1'b0);
        end
        write_word(96'(32'h7FFFF7EC), 31, 1'b0);
        write_word(96'h1_0000_F00C, 33, 1'b0);
        write_word({32'h80A3A00C, 64'h0123_4567_89AB_CDEF}, 96, 1'b1);
        write_word(96'(32'h0001F00C), 32, 1'b1);
        do_reset();
        finish_test();
    end
endmodule
